// ===== hdl/acf_flags.sv
/*
 * Condition-flag datapath: computes add, subtract, rotate and clear
 * results, passes logic results through, and keeps the negative, overflow, zero, nibble carry
 * and carry flags in one 8-bit register.
 * Assumes the execute stage presents one operation per clock, with
 * operands already fetched and the destination decoded.
 */
// Functional notes
// - Flag destination: drop result, flags update
// - Clear of flags sets only zero
// - Bit, swap and moves write flags directly
// - Flag register is an ordinary operand
// - Carry and nibble carry mean no borrow on subtract
// - Subtract adds complement; carry set means no borrow
// - Negative follows result bit 7 on add, subtract and logic
// - Overflow when signed sign bit flips
// - Rotates load nibble carry from bit 4/3
// - Add/subtract carry out of bit 7
// - Rotates load carry from bit 7 or 0
`timescale 1ns/1ps
module acf_flags
    import acf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Operation request from execute stage
    input wire logic op_valid_in,
    input wire acf_op_t op_in,
    input wire logic [7:0] opnd_a_in,
    input wire logic [7:0] opnd_b_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic dest_is_flags_in,
    // Result to the destination register
    output logic [7:0] result_out,
    output logic result_we_out,
    // Flag register view
    output logic [7:0] flags_out
);

    // Flag register, implemented bits only are kept
    logic [7:0] flags;
    // Combinational result and flag candidates
    logic [7:0] next_result;
    logic [7:0] next_flags;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] addend;
    logic arith;
    logic rotate;
    logic direct;
    logic affects;

    // Bit mask of one selected bit
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        bit_mask = 8'h01 << sel;
    endfunction : bit_mask

    // True for operations that subtract opnd_b from opnd_a
    function automatic logic is_sub(input acf_op_t op);
        is_sub = (op == ACF_OP_SUBTRACT_W_FROM_LITERAL) ||
                 (op == ACF_OP_SUBTRACT_W_FROM_FILE);
    endfunction : is_sub

    // Class decode of the request
    always_comb begin
        arith = (op_in == ACF_OP_ADD_W_TO_FILE) ||
                (op_in == ACF_OP_ADD_LITERAL_TO_W) || is_sub(op_in);
        rotate = (op_in == ACF_OP_ROTATE_RIGHT_THROUGH_CARRY) ||
                 (op_in == ACF_OP_ROTATE_LEFT_THROUGH_CARRY);
        // These leave every flag alone when the target is a normal register
        direct = (op_in == ACF_OP_BIT_CLEAR_FILE) ||
                 (op_in == ACF_OP_BIT_SET_FILE) ||
                 (op_in == ACF_OP_SWAP_NIBBLES_FILE) ||
                 (op_in == ACF_OP_MOVE_FILE_TO_FILE) ||
                 (op_in == ACF_OP_MOVE_W_TO_FILE);
        affects = arith || rotate || (op_in == ACF_OP_CLEAR_FILE) ||
                  (op_in == ACF_OP_LOGIC);
    end

    // Subtract is an add of the two's complement of opnd_b
    always_comb begin
        addend = is_sub(op_in) ? ~opnd_b_in : opnd_b_in;
        sum9 = {1'b0, opnd_a_in} + {1'b0, addend}
             + {8'h00, is_sub(op_in)};
        sum5 = {1'b0, opnd_a_in[3:0]} + {1'b0, addend[3:0]}
             + {4'h0, is_sub(op_in)};
    end

    // Result and new flag value
    always_comb begin
        next_result = 8'h00;
        next_flags = flags;
        case (op_in)
            ACF_OP_ADD_W_TO_FILE, ACF_OP_ADD_LITERAL_TO_W,
            ACF_OP_SUBTRACT_W_FROM_LITERAL,
            ACF_OP_SUBTRACT_W_FROM_FILE: begin
                next_result = sum9[7:0];
                // Borrow shows as a cleared carry after subtract
                next_flags[FLAG_CARRY] = sum9[8];
                next_flags[FLAG_NIBBLE] = sum5[4];
                // Same-sign operands giving a different sign
                next_flags[FLAG_OVF] = (opnd_a_in[7] == addend[7]) &&
                    (sum9[7] != opnd_a_in[7]);
            end
            ACF_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                next_result = {flags[FLAG_CARRY], opnd_a_in[7:1]};
                next_flags[FLAG_CARRY] = opnd_a_in[0];
                next_flags[FLAG_NIBBLE] = opnd_a_in[NIB_HI_BIT];
            end
            ACF_OP_ROTATE_LEFT_THROUGH_CARRY: begin
                next_result = {opnd_a_in[6:0], flags[FLAG_CARRY]};
                next_flags[FLAG_CARRY] = opnd_a_in[7];
                next_flags[FLAG_NIBBLE] = opnd_a_in[NIB_LO_BIT];
            end
            ACF_OP_CLEAR_FILE: begin
                next_result = 8'h00;
            end
            ACF_OP_LOGIC: begin
                // Logic result precomputed by the execute stage
                next_result = opnd_a_in;
            end
            ACF_OP_BIT_CLEAR_FILE: begin
                next_result = opnd_a_in & ~bit_mask(bit_sel_in);
            end
            ACF_OP_BIT_SET_FILE: begin
                next_result = opnd_a_in | bit_mask(bit_sel_in);
            end
            ACF_OP_SWAP_NIBBLES_FILE: begin
                next_result = {opnd_a_in[3:0], opnd_a_in[7:4]};
            end
            ACF_OP_MOVE_FILE_TO_FILE, ACF_OP_MOVE_W_TO_FILE: begin
                next_result = opnd_a_in;
            end
            default: begin
                next_result = 8'h00;
            end
        endcase
        // Zero tracking for flag-affecting ops, negative for arithmetic and logic
        if (affects) begin
            next_flags[FLAG_ZERO] = (next_result == 8'h00);
            if (arith || (op_in == ACF_OP_LOGIC)) begin
                next_flags[FLAG_NEG] = next_result[7];
            end
            // Clear only touches zero; the rest keep their value
            if (op_in == ACF_OP_CLEAR_FILE) begin
                next_flags = flags;
                next_flags[FLAG_ZERO] = 1'b1;
            end
        end
    end

    // Flag register update
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags <= FLAG_RESET;
        end else if (op_valid_in) begin
            if (dest_is_flags_in && affects) begin
                // Result is discarded, flags win
                flags <= next_flags & FLAG_IMPL_MASK;
            end else if (dest_is_flags_in && direct) begin
                // Plain write like any other register
                flags <= next_result & FLAG_IMPL_MASK;
            end else if (affects) begin
                flags <= next_flags & FLAG_IMPL_MASK;
            end
        end
    end

    // Registered result port towards the destination
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            result_out <= 8'h00;
            result_we_out <= 1'b0;
        end else begin
            result_out <= next_result;
            // No result write when the flags are the target
            result_we_out <= op_valid_in && !dest_is_flags_in &&
                             (op_in != ACF_OP_NONE);
        end
    end

    // Unimplemented bits read as zero
    assign flags_out = flags & FLAG_IMPL_MASK;

    // Checks beside the logic
    a_clear_sets_zero: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_CLEAR_FILE |=> flags_out[FLAG_ZERO]
        && flags_out[1:0] == $past(flags_out[1:0]))
        else $error("clear did not set only zero");
    // Upper flags must also survive a clear
    a_clear_keeps_sign: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_CLEAR_FILE
        |=> flags_out[4:3] == $past(flags_out[4:3]))
        else $error("clear changed negative or overflow");
    a_flag_dest_nowrite: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && dest_is_flags_in |=> !result_we_out)
        else $error("result written while flags were target");
    // A normal destination must still see its write pulse
    a_result_we_pulse: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && !dest_is_flags_in && op_in != ACF_OP_NONE
        |=> result_we_out)
        else $error("result write pulse missing");
    a_direct_keeps: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && direct && !dest_is_flags_in
        |=> $stable(flags_out))
        else $error("direct op changed flags");
    a_direct_write: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && direct && dest_is_flags_in
        |=> flags_out == ($past(next_result) & FLAG_IMPL_MASK))
        else $error("flag register write lost");
    // Moves copy the operand as it stands, upper bits dropped
    a_move_write: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && dest_is_flags_in &&
        (op_in == ACF_OP_MOVE_W_TO_FILE || op_in == ACF_OP_MOVE_FILE_TO_FILE)
        |=> flags_out == ($past(opnd_a_in) & FLAG_IMPL_MASK))
        else $error("move into flags wrong");
    // Swap lands its exchanged nibbles in the flags
    a_swap_write: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && dest_is_flags_in && op_in == ACF_OP_SWAP_NIBBLES_FILE
        |=> flags_out == ({$past(opnd_a_in[3:0]), $past(opnd_a_in[7:4])}
            & FLAG_IMPL_MASK))
        else $error("swap into flags wrong");
    // Bit set written independently of the design's mask function
    a_bit_set_write: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && dest_is_flags_in && op_in == ACF_OP_BIT_SET_FILE
        |=> flags_out == (($past(opnd_a_in) | (8'h01 << $past(bit_sel_in)))
            & FLAG_IMPL_MASK))
        else $error("bit set into flags wrong");
    a_add_carry: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_ADD_W_TO_FILE
        |=> flags_out[FLAG_CARRY] ==
            $past(({1'b0, opnd_a_in} + {1'b0, opnd_b_in}) > 9'h0FF))
        else $error("add carry wrong");
    a_sub_noborrow: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_SUBTRACT_W_FROM_FILE
        |=> flags_out[FLAG_CARRY] == $past(opnd_a_in >= opnd_b_in))
        else $error("subtract borrow polarity wrong");
    a_sub_nibble: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_SUBTRACT_W_FROM_LITERAL
        |=> flags_out[FLAG_NIBBLE] ==
            $past(opnd_a_in[3:0] >= opnd_b_in[3:0]))
        else $error("digit borrow wrong");
    a_add_nibble: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_ADD_LITERAL_TO_W
        |=> flags_out[FLAG_NIBBLE] ==
            $past(({1'b0, opnd_a_in[3:0]} + {1'b0, opnd_b_in[3:0]}) > 5'h0F))
        else $error("digit carry wrong");
    a_neg_zero: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && arith && !dest_is_flags_in
        |=> flags_out[FLAG_NEG] == result_out[7] &&
            flags_out[FLAG_ZERO] == (result_out == 8'h00))
        else $error("negative or zero wrong");
    a_ovf_sign: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_ADD_W_TO_FILE && !dest_is_flags_in
        |=> flags_out[FLAG_OVF] ==
            ($past(opnd_a_in[7]) == $past(opnd_b_in[7]) &&
             result_out[7] != $past(opnd_a_in[7])))
        else $error("overflow wrong");
    // Subtract overflows only when the operand signs differ
    a_sub_ovf: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_SUBTRACT_W_FROM_FILE
        |=> flags_out[FLAG_OVF] ==
            ($past(opnd_a_in[7]) != $past(opnd_b_in[7]) &&
             result_out[7] != $past(opnd_a_in[7])))
        else $error("subtract overflow wrong");
    a_rotate_left: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_ROTATE_LEFT_THROUGH_CARRY
        |=> flags_out[FLAG_CARRY] == $past(opnd_a_in[7]) &&
            flags_out[FLAG_NIBBLE] == $past(opnd_a_in[3]))
        else $error("rotate left flags wrong");
    a_rotate_right: assert property (@(posedge clk_in)
        disable iff (rst_in)
        op_valid_in && op_in == ACF_OP_ROTATE_RIGHT_THROUGH_CARRY
        |=> flags_out[FLAG_CARRY] == $past(opnd_a_in[0]) &&
            flags_out[FLAG_NIBBLE] == $past(opnd_a_in[4]))
        else $error("rotate right flags wrong");
    // With no request the flag register holds its value
    a_idle_keeps: assert property (@(posedge clk_in)
        disable iff (rst_in)
        !op_valid_in |=> $stable(flags_out))
        else $error("flags changed without a request");

    // Main scenarios
    c_sub_borrow: cover property (@(posedge clk_in)
        op_valid_in && op_in == ACF_OP_SUBTRACT_W_FROM_FILE
        && opnd_a_in < opnd_b_in);
    c_flag_dest_arith: cover property (@(posedge clk_in)
        op_valid_in && arith && dest_is_flags_in);
    c_clear_flags: cover property (@(posedge clk_in)
        op_valid_in && op_in == ACF_OP_CLEAR_FILE && dest_is_flags_in);
    c_add_overflow: cover property (@(posedge clk_in)
        op_valid_in && arith ##1 flags_out[FLAG_OVF]);

endmodule : acf_flags

// ===== hdl/acf_pkg.sv
/*
 * Package for the ALU condition-flag block: opcode encodings, flag bit
 * positions and reset value.
 * Assumes the execute stage drives operation codes from acf_op_t.
 */
package acf_pkg;
    // Flag bit positions inside the 8-bit flag register
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_NIBBLE = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_OVF = 3;
    localparam int FLAG_NEG = 4;
    // Implemented bits; bits 7..5 read as zero
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h1F;
    // Value after reset (unknown in silicon, zero here)
    localparam logic [7:0] FLAG_RESET = 8'h00;
    // Nibble boundary bits used by rotates
    localparam int NIB_HI_BIT = 4;
    localparam int NIB_LO_BIT = 3;

    // Operations the execute stage can request
    typedef enum logic [3:0] {
        ACF_OP_NONE,
        ACF_OP_ADD_W_TO_FILE,
        ACF_OP_ADD_LITERAL_TO_W,
        ACF_OP_SUBTRACT_W_FROM_LITERAL,
        ACF_OP_SUBTRACT_W_FROM_FILE,
        ACF_OP_ROTATE_RIGHT_THROUGH_CARRY,
        ACF_OP_ROTATE_LEFT_THROUGH_CARRY,
        ACF_OP_CLEAR_FILE,
        ACF_OP_LOGIC,
        ACF_OP_BIT_CLEAR_FILE,
        ACF_OP_BIT_SET_FILE,
        ACF_OP_SWAP_NIBBLES_FILE,
        ACF_OP_MOVE_FILE_TO_FILE,
        ACF_OP_MOVE_W_TO_FILE
    } acf_op_t;
endpackage : acf_pkg

// ===== testbench/alu_condition_flags_tb_top.sv
/*
 * Self-checking bench for the condition-flag datapath: drives operations
 * one per clock and compares result, write pulse and flags.
 * Assumes the package and the datapath module are compiled first.
 */
`timescale 1ns/1ps
module alu_condition_flags_tb_top;
    import acf_pkg::*;

    // Clock and reset
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    // Operation request
    logic op_valid_in = 1'b0;
    acf_op_t op_in = ACF_OP_NONE;
    logic [7:0] opnd_a_in = 8'h00;
    logic [7:0] opnd_b_in = 8'h00;
    logic [2:0] bit_sel_in = 3'h0;
    logic dest_is_flags_in = 1'b0;
    // Observed outputs
    logic [7:0] result_out;
    logic result_we_out;
    logic [7:0] flags_out;
    // Bookkeeping
    int failures = 0;
    int n_checks = 0;

    // Twenty nanosecond period
    always #10 clk_in = ~clk_in;

    acf_flags acf_flags_i (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .op_valid_in(op_valid_in),
        .op_in(op_in),
        .opnd_a_in(opnd_a_in),
        .opnd_b_in(opnd_b_in),
        .bit_sel_in(bit_sel_in),
        .dest_is_flags_in(dest_is_flags_in),
        .result_out(result_out),
        .result_we_out(result_we_out),
        .flags_out(flags_out)
    );

    // Compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One operation launched at the falling edge, checked after the rise
    task automatic run(input acf_op_t op, input logic [7:0] a,
                       input logic [7:0] b, input logic [2:0] sel,
                       input logic dst, input logic [7:0] res,
                       input logic we, input logic [7:0] fl);
        @(negedge clk_in);
        op_valid_in = 1'b1;
        op_in = op;
        opnd_a_in = a;
        opnd_b_in = b;
        bit_sel_in = sel;
        dest_is_flags_in = dst;
        @(posedge clk_in);
        #1;
        // Result only matters when it is written
        if (we) begin
            chk(result_out, res);
        end
        chk({7'h00, result_we_out}, {7'h00, we});
        chk(flags_out, fl);
    endtask : run

    // Verdict and end of run
    task automatic results;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Watchdog: the sequence needs well under a microsecond per step
    initial begin
        #100000;
        failures++;
        results();
    end

    // Main sequence; operations run back to back
    initial begin
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        chk(flags_out, FLAG_RESET);
        chk({7'h00, result_we_out}, 8'h00);
        // Adds: sign change, nibble and full carry, zero
        run(ACF_OP_ADD_W_TO_FILE, 8'h7F, 8'h01, 3'h0, 1'b0,
            8'h80, 1'b1, 8'h1A);
        run(ACF_OP_ADD_W_TO_FILE, 8'hFF, 8'h01, 3'h0, 1'b0,
            8'h00, 1'b1, 8'h07);
        // Subtracts: carry set means no borrow; then an add with nibble carry
        run(ACF_OP_SUBTRACT_W_FROM_FILE, 8'h05, 8'h03, 3'h0, 1'b0,
            8'h02, 1'b1, 8'h03);
        run(ACF_OP_SUBTRACT_W_FROM_LITERAL, 8'h03, 8'h05, 3'h0, 1'b0,
            8'hFE, 1'b1, 8'h10);
        run(ACF_OP_SUBTRACT_W_FROM_FILE, 8'h80, 8'h01, 3'h0, 1'b0,
            8'h7F, 1'b1, 8'h09);
        run(ACF_OP_ADD_LITERAL_TO_W, 8'h08, 8'h08, 3'h0, 1'b0,
            8'h10, 1'b1, 8'h02);
        // Rotates through carry; negative and overflow kept
        run(ACF_OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h11, 8'h00, 3'h0, 1'b0,
            8'h08, 1'b1, 8'h03);
        run(ACF_OP_ROTATE_LEFT_THROUGH_CARRY, 8'h80, 8'h00, 3'h0, 1'b0,
            8'h01, 1'b1, 8'h01);
        run(ACF_OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h01, 8'h00, 3'h0, 1'b0,
            8'h80, 1'b1, 8'h01);
        // Logic results touch zero and negative only
        run(ACF_OP_LOGIC, 8'h00, 8'h00, 3'h0, 1'b0,
            8'h00, 1'b1, 8'h05);
        run(ACF_OP_LOGIC, 8'h90, 8'h00, 3'h0, 1'b0,
            8'h90, 1'b1, 8'h11);
        // Clear aimed at the flags keeps the others
        run(ACF_OP_CLEAR_FILE, 8'hAA, 8'h00, 3'h0, 1'b1,
            8'h00, 1'b0, 8'h15);
        // Direct writes into the flags, upper bits read zero; then a clear to a normal file
        run(ACF_OP_MOVE_W_TO_FILE, 8'hFF, 8'h00, 3'h0, 1'b1,
            8'h00, 1'b0, 8'h1F);
        run(ACF_OP_BIT_CLEAR_FILE, 8'h1F, 8'h00, 3'h2, 1'b1,
            8'h00, 1'b0, 8'h1B);
        run(ACF_OP_BIT_SET_FILE, 8'h00, 8'h00, 3'h4, 1'b1,
            8'h00, 1'b0, 8'h10);
        run(ACF_OP_SWAP_NIBBLES_FILE, 8'hA5, 8'h00, 3'h0, 1'b1,
            8'h00, 1'b0, 8'h1A);
        run(ACF_OP_MOVE_FILE_TO_FILE, 8'h03, 8'h00, 3'h0, 1'b1,
            8'h00, 1'b0, 8'h03);
        run(ACF_OP_CLEAR_FILE, 8'h55, 8'h00, 3'h0, 1'b0,
            8'h00, 1'b1, 8'h07);
        // Same ops to a normal file leave the flags alone
        run(ACF_OP_BIT_SET_FILE, 8'h00, 8'h00, 3'h7, 1'b0,
            8'h80, 1'b1, 8'h07);
        run(ACF_OP_BIT_CLEAR_FILE, 8'hFF, 8'h00, 3'h0, 1'b0,
            8'hFE, 1'b1, 8'h07);
        run(ACF_OP_SWAP_NIBBLES_FILE, 8'hA5, 8'h00, 3'h0, 1'b0,
            8'h5A, 1'b1, 8'h07);
        run(ACF_OP_MOVE_W_TO_FILE, 8'h00, 8'h00, 3'h0, 1'b0,
            8'h00, 1'b1, 8'h07);
        run(ACF_OP_MOVE_FILE_TO_FILE, 8'h80, 8'h00, 3'h0, 1'b0,
            8'h80, 1'b1, 8'h07);
        // Arithmetic aimed at the flags drops its result
        run(ACF_OP_ADD_W_TO_FILE, 8'h7F, 8'h01, 3'h0, 1'b1,
            8'h00, 1'b0, 8'h1A);
        // Rotate keeps negative and overflow, sets carry and zero
        run(ACF_OP_ROTATE_LEFT_THROUGH_CARRY, 8'h80, 8'h00, 3'h0, 1'b1,
            8'h00, 1'b0, 8'h1D);
        // Idle code and a dropped valid change nothing
        run(ACF_OP_NONE, 8'hFF, 8'h01, 3'h0, 1'b0,
            8'h00, 1'b0, 8'h1D);
        // Valid low with a live opcode must be ignored
        @(negedge clk_in);
        op_valid_in = 1'b0;
        op_in = ACF_OP_ADD_W_TO_FILE;
        @(posedge clk_in);
        #1;
        chk({7'h00, result_we_out}, 8'h00);
        chk(flags_out, 8'h1D);
        // Second reset in mid-run
        @(negedge clk_in);
        rst_in = 1'b1;
        @(negedge clk_in);
        rst_in = 1'b0;
        chk(flags_out, FLAG_RESET);
        chk({7'h00, result_we_out}, 8'h00);
        run(ACF_OP_SUBTRACT_W_FROM_FILE, 8'h00, 8'h01, 3'h0, 1'b0,
            8'hFF, 1'b1, 8'h10);
        results();
    end
endmodule : alu_condition_flags_tb_top
